// ===== logic/acs_defs.svh
// Purpose: Constants for the area decoder and chip-select block.
// Assumes: Included by bare name from the package and the design modules.
// Notes: Definitions only.
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH
`define ACS_AREA_MSB 26
`define ACS_AREA_LSB 24
`define ACS_WIDTH_BIT 27
`define ACS_AREA0 3'h0
`define ACS_AREA1 3'h1
`define ACS_AREA2 3'h2
`define ACS_AREA5 3'h5
`define ACS_AREA6 3'h6
`define ACS_AREA7 3'h7
`define ACS_MODE_EXT8 3'h0
`define ACS_MODE_EXT16 3'h1
`define ACS_MODE_ROM32 3'h2
`define ACS_ROM_KEEP 16
`define ACS_PERI_KEEP 9
`define ACS_PERI_WIDTH_BIT 8
`define ACS_MIO_WIDTH_BIT 14
`define ACS_RAM8K_KEEP 13
`define ACS_RAM4K_KEEP 12
`define ACS_EXT_KEEP 22
`define ACS_CS_IDLE 8'hff
`endif

// ===== logic/acs_pkg.sv
// Purpose: Types shared by the area decoder modules.
// Assumes: acs_defs.svh is on the include path.
// Notes: Constants live in the header as macros.
`include "acs_defs.svh"
package acs_pkg;
  typedef enum logic [2:0] {
    ACS_TGT_EXT = 3'h0,
    ACS_TGT_DRAM = 3'h1,
    ACS_TGT_MIO = 3'h2,
    ACS_TGT_ROM = 3'h3,
    ACS_TGT_RAM = 3'h4,
    ACS_TGT_PERI = 3'h5
  } acs_target_t;
  typedef enum logic [1:0] {
    ACS_BW8 = 2'h0,
    ACS_BW16 = 2'h1,
    ACS_BW32 = 2'h2
  } acs_width_t;
  typedef struct packed {
    acs_target_t target;
    acs_width_t width;
    logic [2:0] area;
    logic [7:0] sel_n;
    logic long_wait_ok;
    logic [2:0] long_waits;
    logic [23:0] addr;
  } acs_decode_t;
endpackage

// ===== logic/acs_area_map.sv
// Purpose: Combinational map from address and config to target, width and select.
// Assumes: Inputs come from registers in the same clock domain.
// Notes: No state; the top registers the result.
`timescale 1ns/1ps
`include "acs_defs.svh"
module acs_area_map
  import acs_pkg::*;
(
  input wire logic [27:0] addr,
  input wire logic [2:0] boot_mode_pins,
  input wire logic dram_space_enable,
  input wire logic row_col_mux_enable,
  input wire logic muxed_io_enable,
  input wire logic ram_is_4k,
  input wire logic [1:0] area02_long_wait,
  input wire logic [1:0] area6_long_wait,
  output acs_decode_t dec
);
  logic [2:0] area;
  logic a27;
  always_comb begin
    area = addr[`ACS_AREA_MSB:`ACS_AREA_LSB];
    a27 = addr[`ACS_WIDTH_BIT];
    dec.area = area;
    dec.target = ACS_TGT_EXT;
    dec.width = a27 ? ACS_BW16 : ACS_BW8;
    dec.long_wait_ok = 1'b0;
    dec.long_waits = {1'b0, area02_long_wait} + 3'h1;
    // Default external aliasing: A23 and A22 are never driven.
    dec.addr = {2'h0, addr[`ACS_EXT_KEEP-1:0]};
    unique case (area)
      `ACS_AREA0: begin
        if (boot_mode_pins == `ACS_MODE_ROM32) begin
          dec.target = ACS_TGT_ROM;
          dec.width = ACS_BW32;
          dec.addr = {8'h00, addr[`ACS_ROM_KEEP-1:0]};
        end else begin
          dec.width = (boot_mode_pins == `ACS_MODE_EXT16) ? ACS_BW16 : ACS_BW8;
          dec.long_wait_ok = 1'b1;
        end
      end
      `ACS_AREA1: begin
        if (dram_space_enable) begin
          dec.target = ACS_TGT_DRAM;
          if (row_col_mux_enable) begin
            dec.addr = addr[23:0];
          end
        end
      end
      `ACS_AREA2: begin
        dec.long_wait_ok = 1'b1;
      end
      `ACS_AREA5: begin
        if (!a27) begin
          dec.target = ACS_TGT_PERI;
          dec.width = addr[`ACS_PERI_WIDTH_BIT] ? ACS_BW16 : ACS_BW8;
          dec.addr = {15'h0000, addr[`ACS_PERI_KEEP-1:0]};
        end else begin
          dec.width = ACS_BW16;
        end
      end
      `ACS_AREA6: begin
        dec.long_waits = {1'b0, area6_long_wait} + 3'h1;
        dec.width = (a27 || addr[`ACS_MIO_WIDTH_BIT]) ? ACS_BW16 : ACS_BW8;
        if (!a27 && muxed_io_enable) begin
          dec.target = ACS_TGT_MIO;
        end else begin
          dec.long_wait_ok = 1'b1;
        end
      end
      `ACS_AREA7: begin
        if (a27) begin
          dec.target = ACS_TGT_RAM;
          dec.width = ACS_BW32;
          dec.addr = ram_is_4k ? {12'h000, addr[`ACS_RAM4K_KEEP-1:0]} :
                                 {11'h000, addr[`ACS_RAM8K_KEEP-1:0]};
        end
      end
      default: begin
        dec.target = ACS_TGT_EXT;
      end
    endcase
    dec.sel_n = `ACS_CS_IDLE;
    if (dec.target == ACS_TGT_EXT || dec.target == ACS_TGT_MIO) begin
      dec.sel_n[area] = 1'b0;
    end
  end
endmodule // acs_area_map

// ===== logic/acs_area_decode.sv
// Purpose: Registered area decoder that drives chip selects for a bus cycle.
// Assumes: Bus requests come from logic on core_clk; config bits are quasi-static.
// Notes: A cycle starts on cyc_start and ends on cyc_end; selects stand between.
//
// Functional notes
// - Address bits 26..24 pick area; only that area's active-low select drops.
// - Selects assert only for off-chip accesses; ROM, peripherals, RAM keep high.
// - Bits 23,22 never driven except in multiplexed DRAM; 4 MB aliasing.
// - Outside areas 0, 5, 6 and 7, bit 27 changes only the lane count, not the location reached.
// - Area 0 target and width come from mode pins: 000, 001, 010.
// - Internal ROM ignores bits 23..16 and keeps area 0 select high.
// - Areas 0 and 2 external insert 1 to 4 long waits from shared field.
// - Area 6 external memory inserts 1 to 4 long waits from own field.
// - Area 1 is external with select when DRAM enable clear, else DRAM.
// - DRAM with row/column multiplexing outputs bits 23..0 over pins.
// - Areas 2..4 always external; width from bit 27; own select.
// - Area 5 with bit 27 clear is peripherals; 512 B aliases; bit 8 width.
// - Area 5 with bit 27 set is 16-bit external memory with select.
// - Area 6 bit 27 clear uses muxed I/O when enabled, else external.
// - Muxed I/O shares address/data; width from bit 14; area 6 select.
// - Area 6 external width 8 only when bits 27 and 14 are clear.
// - Area 7 is 8-bit external when bit 27 clear, 32-bit RAM otherwise.
// - Internal RAM aliases at 8 kB or 4 kB depending on variant.
// - Bits 31..28 are ignored and never driven off-chip.
// - Elsewhere bit 27 clear means 8-bit path, set means 16-bit path.
`timescale 1ns/1ps
`include "acs_defs.svh"
module acs_area_decode
  import acs_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cyc_start,
  input wire logic cyc_end,
  input wire logic [31:0] cyc_addr,
  input wire logic [2:0] boot_mode_pins,
  input wire logic dram_space_enable,
  input wire logic row_col_mux_enable,
  input wire logic muxed_io_enable,
  input wire logic ram_is_4k,
  input wire logic area02_long_wait_hi,
  input wire logic area02_long_wait_lo,
  input wire logic area6_long_wait_hi,
  input wire logic area6_long_wait_lo,
  output logic [7:0] area_select_n,
  output logic [23:0] ext_addr,
  output logic [2:0] cur_area,
  output acs_target_t cur_target,
  output acs_width_t cur_width,
  output logic [2:0] long_wait_count,
  output logic cyc_active
);
  // ---------------------------------------------------------------
  // Mode pin synchroniser
  // ---------------------------------------------------------------
  // Mode pins come straight from package balls, so they are double-flopped.
  logic [2:0] mode_meta_ff;
  logic [2:0] mode_sync_ff;
  logic [2:0] nxt_mode_meta;
  logic [2:0] nxt_mode_sync;
  always_comb begin
    nxt_mode_meta = boot_mode_pins;
    nxt_mode_sync = mode_meta_ff;
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_meta_ff <= 3'h0;
      mode_sync_ff <= 3'h0;
    end else begin
      mode_meta_ff <= nxt_mode_meta;
      mode_sync_ff <= nxt_mode_sync;
    end
  end

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  acs_decode_t dec;
  acs_area_map u_map (
    .addr(cyc_addr[27:0]),
    .boot_mode_pins(mode_sync_ff),
    .dram_space_enable(dram_space_enable),
    .row_col_mux_enable(row_col_mux_enable),
    .muxed_io_enable(muxed_io_enable),
    .ram_is_4k(ram_is_4k),
    .area02_long_wait({area02_long_wait_hi, area02_long_wait_lo}),
    .area6_long_wait({area6_long_wait_hi, area6_long_wait_lo}),
    .dec(dec)
  );

  // ---------------------------------------------------------------
  // Cycle registers
  // ---------------------------------------------------------------
  // The decode is latched at cycle start so that a changing request
  // address cannot glitch a select in the middle of wait states.
  logic [7:0] sel_n_ff;
  logic [23:0] addr_ff;
  logic [2:0] area_ff;
  acs_target_t target_ff;
  acs_width_t width_ff;
  logic [2:0] lw_ff;
  logic active_ff;
  logic [7:0] nxt_sel_n;
  logic [23:0] nxt_addr;
  logic [2:0] nxt_area;
  acs_target_t nxt_target;
  acs_width_t nxt_width;
  logic [2:0] nxt_lw;
  logic nxt_active;
  always_comb begin
    nxt_sel_n = sel_n_ff;
    nxt_addr = addr_ff;
    nxt_area = area_ff;
    nxt_target = target_ff;
    nxt_width = width_ff;
    nxt_lw = lw_ff;
    nxt_active = active_ff;
    if (cyc_start) begin
      nxt_active = 1'b1;
      nxt_sel_n = dec.sel_n;
      nxt_addr = dec.addr;
      nxt_area = dec.area;
      nxt_target = dec.target;
      nxt_width = dec.width;
      nxt_lw = dec.long_wait_ok ? dec.long_waits : 3'h0;
    end else if (cyc_end) begin
      nxt_active = 1'b0;
      nxt_sel_n = `ACS_CS_IDLE;
      nxt_lw = 3'h0;
    end
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_n_ff <= `ACS_CS_IDLE;
      addr_ff <= 24'h000000;
      area_ff <= 3'h0;
      target_ff <= ACS_TGT_EXT;
      width_ff <= ACS_BW8;
      lw_ff <= 3'h0;
      active_ff <= 1'b0;
    end else begin
      sel_n_ff <= nxt_sel_n;
      addr_ff <= nxt_addr;
      area_ff <= nxt_area;
      target_ff <= nxt_target;
      width_ff <= nxt_width;
      lw_ff <= nxt_lw;
      active_ff <= nxt_active;
    end
  end
  always_comb begin
    area_select_n = sel_n_ff;
    ext_addr = addr_ff;
    cur_area = area_ff;
    cur_target = target_ff;
    cur_width = width_ff;
    long_wait_count = lw_ff;
    cyc_active = active_ff;
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_one_hot_sel: assert property (@(posedge core_clk) disable iff (!reset_n)
    $countones(~sel_n_ff) <= 1)
    else $error("More than one chip select low.");
  chk_sel_area: assert property (@(posedge core_clk) disable iff (!reset_n)
    (sel_n_ff != `ACS_CS_IDLE) |-> (sel_n_ff[area_ff] == 1'b0))
    else $error("Select low does not match area.");
  chk_internal_idle: assert property (@(posedge core_clk) disable iff (!reset_n)
    (target_ff inside {ACS_TGT_ROM, ACS_TGT_RAM, ACS_TGT_PERI, ACS_TGT_DRAM})
    |-> sel_n_ff == `ACS_CS_IDLE)
    else $error("Select low for internal or DRAM target.");
  chk_alias_bits: assert property (@(posedge core_clk) disable iff (!reset_n)
    (target_ff != ACS_TGT_DRAM) |-> addr_ff[23:22] == 2'h0)
    else $error("Alias bits driven outside DRAM.");
  chk_rom_alias: assert property (@(posedge core_clk) disable iff (!reset_n)
    (target_ff == ACS_TGT_ROM) |-> (addr_ff[23:16] == 8'h00 && width_ff == ACS_BW32))
    else $error("ROM alias or width wrong.");
  chk_peri_alias: assert property (@(posedge core_clk) disable iff (!reset_n)
    (target_ff == ACS_TGT_PERI) |-> (addr_ff[23:9] == 15'h0000 && area_ff == `ACS_AREA5))
    else $error("Peripheral alias wrong.");
  chk_start_latch: assert property (@(posedge core_clk) disable iff (!reset_n)
    cyc_start |=> (sel_n_ff == $past(dec.sel_n) && active_ff))
    else $error("Select not latched at cycle start.");
  chk_hold_sel: assert property (@(posedge core_clk) disable iff (!reset_n)
    (active_ff && !cyc_start && !cyc_end) |=> $stable(sel_n_ff))
    else $error("Select changed mid cycle.");
  chk_end_release: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cyc_end && !cyc_start) |=> (sel_n_ff == `ACS_CS_IDLE && !active_ff))
    else $error("Select not released at cycle end.");
  chk_long_wait: assert property (@(posedge core_clk) disable iff (!reset_n)
    (active_ff && lw_ff != 3'h0) |-> (lw_ff <= 3'h4 && area_ff inside {3'h0, 3'h2, 3'h6}))
    else $error("Long wait out of range or area.");
  chk_ram_alias: assert property (@(posedge core_clk) disable iff (!reset_n)
    (target_ff == ACS_TGT_RAM) |-> addr_ff[23:13] == 11'h000)
    else $error("RAM alias wrong.");

  // The request is decoded again here, apart from the map, so that a slip in
  // the map cannot hide behind a check that reuses its own output.
  logic [2:0] req_area;
  logic req_wide;
  logic req_rom_mode;
  always_comb begin
    req_area = cyc_addr[`ACS_AREA_MSB:`ACS_AREA_LSB];
    req_wide = cyc_addr[`ACS_WIDTH_BIT];
    req_rom_mode = (mode_sync_ff == `ACS_MODE_ROM32);
  end
  chk_area_index: assert property (@(posedge core_clk) disable iff (!reset_n)
    cyc_start |=> area_ff == $past(req_area))
    else $error("Latched area does not match address bits.");
  chk_plain_select: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cyc_start && req_area inside {`ACS_AREA2, 3'h3, 3'h4})
    |=> (sel_n_ff == ~(8'h01 << area_ff) && target_ff == ACS_TGT_EXT))
    else $error("Area 2 to 4 select or target wrong.");
  chk_plain_width: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cyc_start && req_area inside {`ACS_AREA1, `ACS_AREA2, 3'h3, 3'h4})
    |=> width_ff == ($past(req_wide) ? ACS_BW16 : ACS_BW8))
    else $error("Width does not follow bit 27.");
  chk_lane_alias: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cyc_start && req_area inside {`ACS_AREA2, 3'h3, 3'h4})
    |=> addr_ff == {2'h0, $past(cyc_addr[`ACS_EXT_KEEP-1:0])})
    else $error("External alias depends on bit 27 or bits 23 and 22.");
  chk_mode_rom: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cyc_start && req_area == `ACS_AREA0 && req_rom_mode)
    |=> (target_ff == ACS_TGT_ROM && width_ff == ACS_BW32 && sel_n_ff == `ACS_CS_IDLE))
    else $error("Area 0 is not internal ROM in ROM mode.");
  chk_mode_ext: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cyc_start && req_area == `ACS_AREA0 && !req_rom_mode)
    |=> (target_ff == ACS_TGT_EXT && sel_n_ff == 8'hfe
         && width_ff == (($past(mode_sync_ff) == `ACS_MODE_EXT16) ? ACS_BW16 : ACS_BW8)))
    else $error("Area 0 external target, select or width wrong.");
  chk_rom_offset: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cyc_start && req_area == `ACS_AREA0 && req_rom_mode)
    |=> addr_ff == {8'h00, $past(cyc_addr[`ACS_ROM_KEEP-1:0])})
    else $error("ROM offset wrong.");
  chk_wait_area02: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cyc_start && (req_area == `ACS_AREA2 || (req_area == `ACS_AREA0 && !req_rom_mode)))
    |=> lw_ff == {1'b0, $past({area02_long_wait_hi, area02_long_wait_lo})} + 3'h1)
    else $error("Area 0 or 2 long wait count wrong.");
  chk_wait_area6: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cyc_start && req_area == `ACS_AREA6 && (req_wide || !muxed_io_enable))
    |=> lw_ff == {1'b0, $past({area6_long_wait_hi, area6_long_wait_lo})} + 3'h1)
    else $error("Area 6 long wait count wrong.");
  chk_wait_none: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cyc_start && req_area inside {`ACS_AREA1, 3'h3, 3'h4, `ACS_AREA5, `ACS_AREA7})
    |=> lw_ff == 3'h0)
    else $error("Long wait given to an area without one.");
  chk_area1_ext: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cyc_start && req_area == `ACS_AREA1 && !dram_space_enable)
    |=> (target_ff == ACS_TGT_EXT && sel_n_ff == 8'hfd))
    else $error("Area 1 external target or select wrong.");
  chk_area1_dram: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cyc_start && req_area == `ACS_AREA1 && dram_space_enable)
    |=> (target_ff == ACS_TGT_DRAM && sel_n_ff == `ACS_CS_IDLE))
    else $error("Area 1 DRAM target or select wrong.");
  chk_dram_mux: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cyc_start && req_area == `ACS_AREA1 && dram_space_enable && row_col_mux_enable)
    |=> addr_ff == $past(cyc_addr[23:0]))
    else $error("Multiplexed DRAM address lost bits.");
  chk_peri_width: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cyc_start && req_area == `ACS_AREA5 && !req_wide)
    |=> (target_ff == ACS_TGT_PERI && sel_n_ff == `ACS_CS_IDLE
         && width_ff == ($past(cyc_addr[`ACS_PERI_WIDTH_BIT]) ? ACS_BW16 : ACS_BW8)))
    else $error("Peripheral target, select or width wrong.");
  chk_area5_ext: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cyc_start && req_area == `ACS_AREA5 && req_wide)
    |=> (target_ff == ACS_TGT_EXT && width_ff == ACS_BW16 && sel_n_ff == 8'hdf))
    else $error("Area 5 external target, select or width wrong.");
  chk_mio_space: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cyc_start && req_area == `ACS_AREA6 && !req_wide && muxed_io_enable)
    |=> (target_ff == ACS_TGT_MIO && sel_n_ff == 8'hbf
         && width_ff == ($past(cyc_addr[`ACS_MIO_WIDTH_BIT]) ? ACS_BW16 : ACS_BW8)))
    else $error("Multiplexed I/O target, select or width wrong.");
  chk_area6_ext: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cyc_start && req_area == `ACS_AREA6 && (req_wide || !muxed_io_enable))
    |=> (target_ff == ACS_TGT_EXT && sel_n_ff == 8'hbf
         && width_ff == (($past(req_wide) || $past(cyc_addr[`ACS_MIO_WIDTH_BIT]))
                         ? ACS_BW16 : ACS_BW8)))
    else $error("Area 6 external target, select or width wrong.");
  chk_area7_ext: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cyc_start && req_area == `ACS_AREA7 && !req_wide)
    |=> (target_ff == ACS_TGT_EXT && width_ff == ACS_BW8 && sel_n_ff == 8'h7f))
    else $error("Area 7 external target, select or width wrong.");
  chk_area7_ram: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cyc_start && req_area == `ACS_AREA7 && req_wide)
    |=> (target_ff == ACS_TGT_RAM && width_ff == ACS_BW32 && sel_n_ff == `ACS_CS_IDLE))
    else $error("Area 7 RAM target, select or width wrong.");
  chk_ram_small: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cyc_start && req_area == `ACS_AREA7 && req_wide && ram_is_4k)
    |=> addr_ff == {12'h000, $past(cyc_addr[`ACS_RAM4K_KEEP-1:0])})
    else $error("Small RAM offset wrong.");
  chk_ram_large: assert property (@(posedge core_clk) disable iff (!reset_n)
    (cyc_start && req_area == `ACS_AREA7 && req_wide && !ram_is_4k)
    |=> addr_ff == {11'h000, $past(cyc_addr[`ACS_RAM8K_KEEP-1:0])})
    else $error("Large RAM offset wrong.");
  chk_idle_high: assert property (@(posedge core_clk) disable iff (!reset_n)
    !active_ff |-> sel_n_ff == `ACS_CS_IDLE)
    else $error("Select low outside a bus cycle.");
  chk_active_low: assert property (@(posedge core_clk) disable iff (!reset_n)
    (active_ff && target_ff inside {ACS_TGT_EXT, ACS_TGT_MIO})
    |-> sel_n_ff[area_ff] == 1'b0)
    else $error("External cycle without its select low.");
endmodule // acs_area_decode

// ===== bench/acs_ext_mem_model.sv
// Purpose: Far-side model of the external parts; times how long a select stays low.
// Assumes: Selects are active low and change just after core_clk rises.
// Notes: Only the length of the most recent selected stretch is exposed.
`timescale 1ns/1ps
module acs_ext_mem_model (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] area_select_n,
  output logic [7:0] low_cycles
);
  logic busy_ff;
  // A stretch is counted whole, so a select that blinks mid-cycle restarts the count.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_ff <= 1'b0;
      low_cycles <= 8'h00;
    end else if (area_select_n != 8'hff) begin
      busy_ff <= 1'b1;
      low_cycles <= busy_ff ? low_cycles + 8'h01 : 8'h01;
    end else begin
      busy_ff <= 1'b0;
    end
  end
endmodule // acs_ext_mem_model

// ===== bench/testbench.sv
// Purpose: Self-checking bench for the area decoder and chip selects.
// Assumes: Outputs settle within two edges of a taken cyc_start.
// Notes: Bits 23..22 of test addresses, and the upper nibble in t_plain, are set to expose aliasing.
`timescale 1ns/1ps
module testbench
  import acs_pkg::*;
;
  logic core_clk, reset_n, cyc_start, cyc_end, dram_space_enable, row_col_mux_enable;
  logic muxed_io_enable, ram_is_4k, area02_long_wait_hi, area02_long_wait_lo;
  logic area6_long_wait_hi, area6_long_wait_lo, cyc_active;
  logic [31:0] cyc_addr;
  logic [2:0] boot_mode_pins, cur_area, long_wait_count;
  logic [7:0] area_select_n, low_cycles;
  logic [23:0] ext_addr;
  acs_target_t cur_target;
  acs_width_t cur_width;
  int miscompares = 0;
  int samples_checked = 0;
  acs_area_decode dut (.core_clk(core_clk), .reset_n(reset_n), .cyc_start(cyc_start),
    .cyc_end(cyc_end), .cyc_addr(cyc_addr), .boot_mode_pins(boot_mode_pins),
    .dram_space_enable(dram_space_enable), .row_col_mux_enable(row_col_mux_enable),
    .muxed_io_enable(muxed_io_enable), .ram_is_4k(ram_is_4k),
    .area02_long_wait_hi(area02_long_wait_hi), .area02_long_wait_lo(area02_long_wait_lo),
    .area6_long_wait_hi(area6_long_wait_hi), .area6_long_wait_lo(area6_long_wait_lo),
    .area_select_n(area_select_n), .ext_addr(ext_addr), .cur_area(cur_area),
    .cur_target(cur_target), .cur_width(cur_width), .long_wait_count(long_wait_count),
    .cyc_active(cyc_active));
  acs_ext_mem_model model (.core_clk(core_clk), .reset_n(reset_n),
    .area_select_n(area_select_n), .low_cycles(low_cycles));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input string n, input logic [23:0] e, input logic [23:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cfg(input logic [2:0] m, input logic dr, mx, io, r4, input logic [3:0] lw);
    @(posedge core_clk);
    boot_mode_pins <= m;
    dram_space_enable <= dr;
    row_col_mux_enable <= mx;
    muxed_io_enable <= io;
    ram_is_4k <= r4;
    {area02_long_wait_hi, area02_long_wait_lo, area6_long_wait_hi, area6_long_wait_lo} <= lw;
    // Mode pins pass a two-flop synchroniser, so let them settle first.
    repeat (3) @(posedge core_clk);
  endtask
  // One whole bus cycle: start, hold, end, then check release and select duration.
  task automatic acc(input logic [31:0] a, input logic [7:0] s, input acs_target_t t,
                     input acs_width_t w, input logic [2:0] lw, input logic [23:0] ea);
    int k;
    @(posedge core_clk);
    cyc_start <= 1'b1;
    cyc_addr <= a;
    @(posedge core_clk);
    cyc_start <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    cmp("select", s, area_select_n);
    cmp("area", a[26:24], cur_area);
    cmp("target", t, cur_target);
    cmp("width", w, cur_width);
    cmp("waits", lw, long_wait_count);
    cmp("address", ea, ext_addr);
    cmp("active", 1'b1, cyc_active);
    repeat (2) @(posedge core_clk);
    cyc_end <= 1'b1;
    @(posedge core_clk);
    cyc_end <= 1'b0;
    #1;
    for (k = 0; k < 8 && cyc_active !== 1'b0; k++) begin
      @(posedge core_clk);
      #1;
    end
    if (cyc_active !== 1'b0) begin
      miscompares++;
      end_of_test;
    end else begin
      cmp("idle select", 8'hff, area_select_n);
      cmp("idle waits", 3'h0, long_wait_count);
      if (s !== 8'hff) cmp("low cycles", 8'h05, low_cycles);
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_plain;
    cfg(3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h4);
    for (int i = 2; i <= 4; i++) begin
      for (int b = 0; b < 2; b++) begin
        acc({4'ha, b[0], i[2:0], 24'hc12345}, ~(8'h01 << i), ACS_TGT_EXT,
            b ? ACS_BW16 : ACS_BW8, (i == 2) ? 3'h2 : 3'h0, 24'h012345);
      end
    end
    $display("test plain areas done");
  endtask
  task automatic t_area0;
    cfg(3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 4'hc);
    acc(32'h08c12345, 8'hfe, ACS_TGT_EXT, ACS_BW8, 3'h4, 24'h012345);
    cfg(3'h1, 1'b0, 1'b0, 1'b0, 1'b0, 4'hc);
    acc(32'h00c12345, 8'hfe, ACS_TGT_EXT, ACS_BW16, 3'h4, 24'h012345);
    cfg(3'h2, 1'b0, 1'b0, 1'b0, 1'b0, 4'hc);
    acc(32'h08c12345, 8'hff, ACS_TGT_ROM, ACS_BW32, 3'h0, 24'h002345);
    cfg(3'h4, 1'b0, 1'b0, 1'b0, 1'b0, 4'hc);
    acc(32'h08c12345, 8'hfe, ACS_TGT_EXT, ACS_BW8, 3'h4, 24'h012345);
    $display("test area0 done");
  endtask
  task automatic t_area1;
    cfg(3'h0, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0);
    acc(32'h09c12345, 8'hfd, ACS_TGT_EXT, ACS_BW16, 3'h0, 24'h012345);
    cfg(3'h0, 1'b1, 1'b0, 1'b0, 1'b0, 4'h0);
    acc(32'h01c12345, 8'hff, ACS_TGT_DRAM, ACS_BW8, 3'h0, 24'h012345);
    cfg(3'h0, 1'b1, 1'b1, 1'b0, 1'b0, 4'h0);
    acc(32'h09c12345, 8'hff, ACS_TGT_DRAM, ACS_BW16, 3'h0, 24'hc12345);
    $display("test area1 done");
  endtask
  task automatic t_area5;
    cfg(3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
    acc(32'h05c12345, 8'hff, ACS_TGT_PERI, ACS_BW16, 3'h0, 24'h000145);
    acc(32'h05c12245, 8'hff, ACS_TGT_PERI, ACS_BW8, 3'h0, 24'h000045);
    acc(32'h0dc12345, 8'hdf, ACS_TGT_EXT, ACS_BW16, 3'h0, 24'h012345);
    $display("test area5 done");
  endtask
  task automatic t_area6;
    cfg(3'h0, 1'b0, 1'b0, 1'b1, 1'b0, 4'h3);
    acc(32'h06c10345, 8'hbf, ACS_TGT_MIO, ACS_BW8, 3'h0, 24'h010345);
    acc(32'h06c14345, 8'hbf, ACS_TGT_MIO, ACS_BW16, 3'h0, 24'h014345);
    acc(32'h0ec10345, 8'hbf, ACS_TGT_EXT, ACS_BW16, 3'h4, 24'h010345);
    cfg(3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
    acc(32'h06c10345, 8'hbf, ACS_TGT_EXT, ACS_BW8, 3'h1, 24'h010345);
    acc(32'h06c14345, 8'hbf, ACS_TGT_EXT, ACS_BW16, 3'h1, 24'h014345);
    $display("test area6 done");
  endtask
  task automatic t_area7;
    cfg(3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
    acc(32'h07c13345, 8'h7f, ACS_TGT_EXT, ACS_BW8, 3'h0, 24'h013345);
    acc(32'h0fc13345, 8'hff, ACS_TGT_RAM, ACS_BW32, 3'h0, 24'h001345);
    cfg(3'h0, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0);
    acc(32'h0fc13345, 8'hff, ACS_TGT_RAM, ACS_BW32, 3'h0, 24'h000345);
    $display("test area7 done");
  endtask
  task automatic t_reset;
    cfg(3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
    @(posedge core_clk);
    cyc_start <= 1'b1;
    cyc_addr <= 32'h03c12345;
    @(posedge core_clk);
    cyc_start <= 1'b0;
    @(posedge core_clk);
    #1;
    cmp("select before reset", 8'hf7, area_select_n);
    @(posedge core_clk);
    reset_n <= 1'b0;
    @(posedge core_clk);
    #1;
    cmp("select in reset", 8'hff, area_select_n);
    cmp("active in reset", 1'b0, cyc_active);
    @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    $display("test reset done");
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    reset_n = 1'b0;
    {cyc_start, cyc_end, dram_space_enable, row_col_mux_enable, muxed_io_enable} = '0;
    {ram_is_4k, area02_long_wait_hi, area02_long_wait_lo} = '0;
    {area6_long_wait_hi, area6_long_wait_lo} = '0;
    cyc_addr = 32'h0;
    boot_mode_pins = 3'h0;
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    t_plain;
    t_area0;
    t_area1;
    t_area5;
    t_area6;
    t_area7;
    t_reset;
    end_of_test;
  end
endmodule // testbench
